// [sram_host_pkg.sv]
package sram_host_pkg;

	// ==========================================================
	// Memory geometry.
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 1;
	localparam int unsigned WORD_COUNT = 65536;

	// ==========================================================
	// Clock and pin timing, in nanoseconds as specified.
	localparam int unsigned CLOCK_PERIOD_NS = 10;
	localparam int unsigned ACCESS_NS = 35;
	localparam int unsigned CS_HIGHZ_NS = 15;
	localparam int unsigned CS_TO_WRITE_END_NS = 25;
	localparam int unsigned ADDR_TO_WRITE_END_NS = 25;
	localparam int unsigned WE_TO_WRITE_END_NS = 20;
	localparam int unsigned DATA_TO_WRITE_END_NS = 15;
	localparam int unsigned POWERDOWN_DELAY_NS = 35;

	// ==========================================================
	// Cycle counts, every least time rounded up to whole cycles.
	localparam int unsigned ACCESS_CYC =
		(ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned HIGHZ_CYC =
		(CS_HIGHZ_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned CS_CYC =
		(CS_TO_WRITE_END_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned ADDR_CYC =
		(ADDR_TO_WRITE_END_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned WE_CYC =
		(WE_TO_WRITE_END_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned DATA_CYC =
		(DATA_TO_WRITE_END_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned POWER_CYC =
		(POWERDOWN_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned WRITE_CYC_A = (CS_CYC > ADDR_CYC) ? CS_CYC : ADDR_CYC;
	localparam int unsigned WRITE_CYC_B = (WE_CYC > DATA_CYC) ? WE_CYC : DATA_CYC;
	localparam int unsigned WRITE_CYC =
		(WRITE_CYC_A > WRITE_CYC_B) ? WRITE_CYC_A : WRITE_CYC_B;

	// ==========================================================
	// Timer loads: a timer loaded with N-1 expires N cycles later.
	localparam int unsigned CNT_W = 3;
	localparam logic [CNT_W-1:0] ACCESS_LOAD = CNT_W'(ACCESS_CYC - 1);
	localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_CYC - 1);
	localparam logic [CNT_W-1:0] HIGHZ_LOAD = CNT_W'(HIGHZ_CYC - 1);
	localparam logic [CNT_W-1:0] POWER_LOAD = CNT_W'(POWER_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

	// ==========================================================
	// Pin bundle driven toward the memory, and a host request.
	typedef struct packed {
		logic [ADDR_W-1:0] wordAddress;
		logic              chipSelectN;
		logic              writeStrobeN;
		logic [DATA_W-1:0] dataToMem;
	} mem_pins_s;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} req_s;

	// ==========================================================
	// Values after reset.
	localparam mem_pins_s PINS_RESET = '{
		wordAddress:  16'h0000,
		chipSelectN:  1'h1,
		writeStrobeN: 1'h1,
		dataToMem:    1'h0
	};
	localparam req_s REQ_RESET = '{write: 1'h0, addr: 16'h0000, data: 1'h0};

endpackage

// [cycle_timer.sv]
`timescale 1ns/100ps
module cycle_timer (
	input  wire logic                            clock,
	input  wire logic                            nrst,
	input  wire logic                            ce,
	input  wire logic                            load,
	input  wire logic [sram_host_pkg::CNT_W-1:0] loadValue,
	output logic      [sram_host_pkg::CNT_W-1:0] count,
	output logic                                 expired
);

	// ==========================================================
	// Down counter that stops at zero.
	logic [sram_host_pkg::CNT_W-1:0] count_q;

	// Loads on request, otherwise counts down to zero and stays.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_q <= sram_host_pkg::CNT_ZERO;
		end else if (ce) begin
			if (load) begin
				count_q <= loadValue;
			end else if (count_q != sram_host_pkg::CNT_ZERO) begin
				count_q <= count_q - sram_host_pkg::CNT_ONE;
			end
		end
	end

	// Status seen by the sequencer.
	assign count = count_q;
	assign expired = (count_q == sram_host_pkg::CNT_ZERO);

endmodule

// [power_tracker.sv]
`timescale 1ns/100ps
module power_tracker (
	input  wire logic                     clock,
	input  wire logic                     nrst,
	input  wire logic                     ce,
	input  wire sram_host_pkg::mem_pins_s pins,
	output logic                          activeCurrentState
);

	// ==========================================================
	// Mirror of the memory's own power state, seen from its pins.
	sram_host_pkg::mem_pins_s        prev_q;
	logic [sram_host_pkg::CNT_W-1:0] count_q;
	logic                            active_q;
	logic                            wake;

	// Wake events: select falls, strobe falls while selected, address
	// moves while selected, or data moves while writing.
	assign wake = (prev_q.chipSelectN & ~pins.chipSelectN)
		| (~pins.chipSelectN & prev_q.writeStrobeN & ~pins.writeStrobeN)
		| (~pins.chipSelectN & (prev_q.wordAddress != pins.wordAddress))
		| (~pins.chipSelectN & ~pins.writeStrobeN
			& (prev_q.dataToMem != pins.dataToMem)); // [RQ23]

	// Keeps the last pin values to find changes.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prev_q <= sram_host_pkg::PINS_RESET;
		end else if (ce) begin
			prev_q <= pins;
		end
	end

	// Active on the edge after a wake event, idle after the powerdown delay.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_q <= sram_host_pkg::CNT_ZERO;
			active_q <= 1'h0;
		end else if (ce) begin
			if (wake) begin
				count_q <= sram_host_pkg::POWER_LOAD; // [RQ21]
				active_q <= 1'h1; // [RQ21]
			end else if (count_q != sram_host_pkg::CNT_ZERO) begin
				count_q <= count_q - sram_host_pkg::CNT_ONE;
			end else begin
				active_q <= 1'h0; // [RQ21]
			end
		end
	end

	assign activeCurrentState = active_q;

endmodule

// [sram_host_ctrl.sv]
`timescale 1ns/100ps
// Notes on behaviour
// [RQ1] Write strobe stays high for the whole of every read.
// [RQ2] The array is written only while select and strobe are both low.
// [RQ3] A write ends when select or strobe rises, whichever is first.
// [RQ4] Setup counts from the later falling edge, hold from the first rising.
// [RQ5] Strobe falling with or before select keeps the memory output off.
// [RQ6] Select rising with or before strobe keeps the memory output off.
// [RQ7] With select held low, new address data is valid within 35 ns.
// [RQ8] Select falling on a stable address gives valid data within 35 ns.
// [RQ9] Old read data stays at least 3 ns after an address change.
// [RQ10] Memory output leaves high impedance no sooner than 3 ns after select.
// [RQ11] Memory output is off again within 15 ns of select rising.
// [RQ12] Select is low at least 25 ns before a write ends.
// [RQ13] Address is valid no later than the start of a write.
// [RQ14] Address is stable 25 ns before write end, may change right after.
// [RQ15] Address does not change before the write has ended.
// [RQ16] Write strobe is low at least 20 ns before the write ends.
// [RQ17] Write data is stable at least 15 ns before the write ends.
// [RQ18] Write data may change as soon as the write ends.
// [RQ19] Memory output turns off within 10 ns of the strobe falling.
// [RQ20] Memory output may drive again as soon as the strobe rises.
// [RQ21] Memory idles 35 ns after a wake event and wakes with no delay.
// [RQ22] Memory holds 65,536 one-bit words on a 16-bit address.
// [RQ23] Select fall, strobe fall, address or data change wake the memory.
// [RQ24] Address moves only while select or strobe is high.
module sram_host_ctrl (
	input  wire logic                              clock,
	input  wire logic                              nrst,
	input  wire logic                              ce,
	input  wire logic                              keepSelected,
	input  wire logic                              reqValid,
	input  wire sram_host_pkg::req_s               req,
	output logic                                   reqReady,
	output logic                                   rspValid,
	output logic                                   rspWrite,
	output logic      [sram_host_pkg::DATA_W-1:0]  rspData,
	output sram_host_pkg::mem_pins_s               memPins,
	input  wire logic [sram_host_pkg::DATA_W-1:0]  memDataOut,
	output logic                                   activeCurrentState
);

	// ==========================================================
	// Sequencer states.
	typedef enum logic [2:0] {
		IDLE,
		SETUP,
		READ,
		WRITE,
		RECOVER
	} cycle_state_e;

	// ==========================================================
	// Registers and internal signals.
	cycle_state_e                    state_q;
	sram_host_pkg::mem_pins_s        pins_q;
	sram_host_pkg::req_s             pending_q;
	logic                            pendingValid_q;
	logic                            isWrite_q;
	logic                            reqReady_q;
	logic                            rspValid_q;
	logic                            rspWrite_q;
	logic [sram_host_pkg::DATA_W-1:0] rspData_q;
	logic                            timerLoad;
	logic [sram_host_pkg::CNT_W-1:0] timerValue;
	logic [sram_host_pkg::CNT_W-1:0] timerCount;
	logic                            timerExpired;
	logic                            taken;
	logic                            sampleNow;
	logic                            burstGo;
	logic                            trackerActive;

	// ==========================================================
	// Request handshake and read decisions.

	// A request is taken on an edge where valid meets a ready flop.
	assign taken = reqValid & reqReady_q;

	// The read data is sampled once the access time has run out.
	assign sampleNow = (state_q == READ) & timerExpired;

	// A read taken at the sample edge keeps select low and only moves
	// the address, which is legal since the strobe stays high.
	assign burstGo = sampleNow & taken & ~req.write; // [RQ24]

	// ==========================================================
	// Interval timer shared by the access and recovery phases.

	// Chooses the load for the phase that the next edge starts.
	always_comb begin
		timerLoad = 1'h0;
		timerValue = sram_host_pkg::CNT_ZERO;
		unique case (state_q)
			IDLE: begin
				timerLoad = 1'h0;
			end
			SETUP: begin
				timerLoad = 1'h1;
				if (isWrite_q) begin
					timerValue = sram_host_pkg::WRITE_LOAD; // [RQ12]
				end else begin
					timerValue = sram_host_pkg::ACCESS_LOAD; // [RQ8]
				end
			end
			READ: begin
				timerLoad = timerExpired;
				if (burstGo) begin
					timerValue = sram_host_pkg::ACCESS_LOAD; // [RQ7]
				end else begin
					timerValue = sram_host_pkg::HIGHZ_LOAD; // [RQ11]
				end
			end
			WRITE: begin
				timerLoad = timerExpired;
				timerValue = sram_host_pkg::HIGHZ_LOAD;
			end
			RECOVER: begin
				timerLoad = 1'h0;
			end
			default: begin
				timerLoad = 1'h0;
			end
		endcase
	end

	cycle_timer phaseTimer (
		.clock     (clock),
		.nrst      (nrst),
		.ce        (ce),
		.load      (timerLoad),
		.loadValue (timerValue),
		.count     (timerCount),
		.expired   (timerExpired)
	);

	// ==========================================================
	// Sequencer state.

	// Walks idle, setup, access and recovery; a burst read stays in access, and a held-over write goes from recovery to setup.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q <= IDLE;
		end else if (ce) begin
			unique case (state_q)
				IDLE: begin
					if (taken) begin
						state_q <= SETUP;
					end
				end
				SETUP: begin
					state_q <= isWrite_q ? WRITE : READ;
				end
				READ: begin
					if (timerExpired && !burstGo) begin
						state_q <= RECOVER;
					end
				end
				WRITE: begin
					if (timerExpired) begin
						state_q <= RECOVER;
					end
				end
				RECOVER: begin
					if (timerExpired) begin
						state_q <= pendingValid_q ? SETUP : IDLE;
					end
				end
				default: begin
					state_q <= IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Memory pins.

	// Address and data move only while select is high, or during a read
	// with the strobe high; select and strobe fall and rise together on
	// writes so that the memory output never turns on inside a write.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pins_q <= sram_host_pkg::PINS_RESET;
		end else if (ce) begin
			unique case (state_q)
				IDLE: begin
					if (taken) begin
						pins_q.wordAddress <= req.addr; // [RQ14] [RQ24]
						pins_q.dataToMem <= req.data;
					end
				end
				SETUP: begin
					pins_q.chipSelectN <= 1'h0; // [RQ13]
					pins_q.writeStrobeN <= ~isWrite_q; // [RQ1] [RQ5]
				end
				READ: begin
					if (burstGo) begin
						pins_q.wordAddress <= req.addr; // [RQ7]
					end else if (timerExpired) begin
						pins_q.chipSelectN <= 1'h1;
					end
				end
				WRITE: begin
					if (timerExpired) begin
						pins_q.chipSelectN <= 1'h1; // [RQ3] [RQ6]
						pins_q.writeStrobeN <= 1'h1; // [RQ2] [RQ16]
					end
				end
				RECOVER: begin
					if (timerExpired && pendingValid_q) begin
						pins_q.wordAddress <= pending_q.addr; // [RQ15]
						pins_q.dataToMem <= pending_q.data; // [RQ18]
					end
				end
				default: begin
					pins_q <= sram_host_pkg::PINS_RESET;
				end
			endcase
		end
	end

	// ==========================================================
	// Access kind and the one held-over request.

	// Records whether the access in flight is a write.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			isWrite_q <= 1'h0;
		end else if (ce) begin
			if (state_q == IDLE && taken) begin
				isWrite_q <= req.write; // [RQ4]
			end else if (state_q == RECOVER && timerExpired && pendingValid_q) begin
				isWrite_q <= pending_q.write;
			end
		end
	end

	// A write taken at a read's sample edge waits for the recovery.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pending_q <= sram_host_pkg::REQ_RESET;
			pendingValid_q <= 1'h0;
		end else if (ce) begin
			if (sampleNow && taken && req.write) begin
				pending_q <= req;
				pendingValid_q <= 1'h1;
			end else if (state_q == RECOVER && timerExpired) begin
				pendingValid_q <= 1'h0;
			end
		end
	end

	// ==========================================================
	// Ready toward the requester.

	// Ready in idle, and on the last access cycle of a read when the
	// requester asks to keep the memory selected.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reqReady_q <= 1'h0;
		end else if (ce) begin
			unique case (state_q)
				IDLE: begin
					reqReady_q <= ~taken;
				end
				READ: begin
					reqReady_q <= keepSelected && !timerExpired
						&& (timerCount == sram_host_pkg::CNT_ONE);
				end
				RECOVER: begin
					reqReady_q <= timerExpired && !pendingValid_q;
				end
				default: begin
					reqReady_q <= 1'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// Response toward the requester.

	// One-cycle pulse per finished access; reads carry the sampled bit.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rspValid_q <= 1'h0;
			rspWrite_q <= 1'h0;
			rspData_q <= 1'h0;
		end else if (ce) begin
			rspValid_q <= 1'h0;
			if (sampleNow) begin
				rspValid_q <= 1'h1;
				rspWrite_q <= 1'h0;
				rspData_q <= memDataOut; // [RQ8] [RQ9]
			end else if (state_q == WRITE && timerExpired) begin
				rspValid_q <= 1'h1; // [RQ17]
				rspWrite_q <= 1'h1;
			end
		end
	end

	// ==========================================================
	// Memory power mirror.

	power_tracker powerMirror (
		.clock              (clock),
		.nrst               (nrst),
		.ce                 (ce),
		.pins               (pins_q),
		.activeCurrentState (trackerActive)
	);

	// ==========================================================
	// Outputs, each straight from a flip-flop.
	assign reqReady = reqReady_q;
	assign rspValid = rspValid_q;
	assign rspWrite = rspWrite_q;
	assign rspData = rspData_q;
	assign memPins = pins_q; // [RQ22]
	assign activeCurrentState = trackerActive;

endmodule

// [sram_word_model.sv]
`timescale 1ns/100ps
module sram_word_model (
	input wire sram_host_pkg::mem_pins_s pins,
	input wire logic                     slow,
	output logic                         dataOut
);
	logic                     mem [0:65535];
	sram_host_pkg::mem_pins_s prev;
	realtime                  readT;
	realtime                  wakeT;
	logic                     wr;
	logic                     awake;
	logic [15:0]              wa;
	logic                     wd;

	// ==========================================================
	// Pin activity: array writes, access timing and wake events.
	initial begin
		wr = 1'b0;
		prev = sram_host_pkg::PINS_RESET;
		readT = 0.0;
		wakeT = -100.0;
		dataOut = 1'b0;
	end

	// The write lands when the overlap of select and strobe ends.
	always @(pins) begin
		if (wr && !(!pins.chipSelectN && !pins.writeStrobeN))
			mem[wa] = wd;
		wr = !pins.chipSelectN && !pins.writeStrobeN;
		if (wr) begin
			wa = pins.wordAddress;
			wd = pins.dataToMem;
		end
		if (pins.wordAddress != prev.wordAddress || pins.chipSelectN != prev.chipSelectN)
			readT = $realtime;
		if ((prev.chipSelectN && !pins.chipSelectN) || (!pins.chipSelectN &&
			(pins.wordAddress != prev.wordAddress || (prev.writeStrobeN && !pins.writeStrobeN)))
			|| (wr && pins.dataToMem != prev.dataToMem))
			wakeT = $realtime;
		prev = pins;
	end

	// A released output shows a changing pattern, never stale data.
	always #1 begin
		awake = ($realtime - wakeT) < 35.0;
		if (pins.chipSelectN || !pins.writeStrobeN)
			dataOut = ~dataOut;
		else if ($realtime - readT >= (slow ? 35.0 : 8.0))
			dataOut = mem[pins.wordAddress];
		else if ($realtime - readT >= 3.0)
			dataOut = ~dataOut;
	end
endmodule

// [sram_host_assertions.sv]
`timescale 1ns/100ps
module sram_host_assertions (
	input wire logic                     clock,
	input wire logic                     nrst,
	input wire logic                     ce,
	input wire logic                     reqValid,
	input wire sram_host_pkg::req_s      req,
	input wire logic                     reqReady,
	input wire logic                     rspValid,
	input wire logic                     rspWrite,
	input wire sram_host_pkg::mem_pins_s memPins,
	input wire logic                     activeCurrentState
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Pin protocol toward the memory.
	a_strobe_with_select: assert property ($fell(memPins.writeStrobeN) |->
		$fell(memPins.chipSelectN)) else $error("strobe fell apart from select");
	a_write_end_together: assert property ($rose(memPins.chipSelectN) &&
		!$past(memPins.writeStrobeN) |-> $rose(memPins.writeStrobeN))
		else $error("write end not on both lines");
	a_write_pulse_len: assert property ($fell(memPins.writeStrobeN) |->
		(!memPins.writeStrobeN && !memPins.chipSelectN) [*3] ##1
		(memPins.writeStrobeN && memPins.chipSelectN)) else $error("bad write pulse");
	a_write_hold_stable: assert property (!memPins.chipSelectN &&
		!memPins.writeStrobeN |-> $stable(memPins.dataToMem) && $stable(memPins.wordAddress))
		else $error("address or data moved during write");
	a_addr_move_safe: assert property (!$stable(memPins.wordAddress) |->
		memPins.writeStrobeN && $past(memPins.writeStrobeN)) else $error("address moved");
	a_read_select_len: assert property ($fell(memPins.chipSelectN) &&
		memPins.writeStrobeN |-> !memPins.chipSelectN [*4]) else $error("read select short");
	a_recovery_gap: assert property ($rose(memPins.chipSelectN) |->
		memPins.chipSelectN [*2]) else $error("select recovery short");

	// ==========================================================
	// Response timing and power tracking; a request counts only when enabled.
	a_read_rsp_time: assert property (ce && reqValid && reqReady && !req.write &&
		memPins.chipSelectN |-> ##6 (rspValid && !rspWrite)) else $error("read late");
	a_write_rsp_time: assert property (ce && reqValid && reqReady && req.write &&
		memPins.chipSelectN |-> ##5 (rspValid && rspWrite)) else $error("write late");
	a_wake_follow: assert property ($fell(memPins.chipSelectN) |=>
		activeCurrentState) else $error("wake not tracked");
	a_idle_power: assert property (memPins.chipSelectN [*6] |->
		!activeCurrentState) else $error("power state stuck active");
endmodule

bind sram_host_ctrl sram_host_assertions sram_host_assertions_i (
	.clock(clock),
	.nrst(nrst),
	.ce(ce),
	.reqValid(reqValid),
	.req(req),
	.reqReady(reqReady),
	.rspValid(rspValid),
	.rspWrite(rspWrite),
	.memPins(memPins),
	.activeCurrentState(activeCurrentState)
);

// [tb.sv]
`timescale 1ns/100ps
module tb;
	logic                             clock;
	logic                             nrst;
	logic                             ce;
	logic                             keepSelected;
	logic                             reqValid;
	logic                             reqReady;
	logic                             rspValid;
	logic                             rspWrite;
	logic                             slow;
	logic                             activeCurrentState;
	logic [sram_host_pkg::DATA_W-1:0] rspData;
	logic [sram_host_pkg::DATA_W-1:0] memDataOut;
	sram_host_pkg::req_s              req;
	sram_host_pkg::mem_pins_s         memPins;
	int                               fails;
	int                               checksDone;
	logic [1:0]                       expQ [$];
	logic [1:0]                       e;
	logic                             shadow [0:65535];
	logic [15:0]                      addrs [0:7];

	sram_host_ctrl sram_host_ctrl_i (.clock(clock), .nrst(nrst), .ce(ce),
		.keepSelected(keepSelected), .reqValid(reqValid), .req(req), .reqReady(reqReady),
		.rspValid(rspValid), .rspWrite(rspWrite), .rspData(rspData), .memPins(memPins),
		.memDataOut(memDataOut), .activeCurrentState(activeCurrentState));
	sram_word_model sram_word_model_i (.pins(memPins), .slow(slow), .dataOut(memDataOut));

	// ==========================================================
	// Clock and shared tasks.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic check(input string what, input logic [18:0] exp, input logic [18:0] got);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report();
		if (fails == 0 && checksDone > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Holds the request until taken and notes the expected response.
	task automatic access(input logic w, input logic [15:0] ad, input logic d);
		int n;
		n = 0;
		reqValid = 1'b1;
		req = '{write: w, addr: ad, data: d};
		while (reqReady !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > 50) begin
				check("request wait", 19'h0, 19'h1);
				final_report();
			end
		end
		if (w)
			shadow[ad] = d;
		expQ.push_back({w, w ? 1'b0 : shadow[ad]});
		@(negedge clock);
	endtask

	task automatic drain();
		int n;
		reqValid = 1'b0;
		for (n = 0; n < 60 && expQ.size() != 0; n++)
			@(negedge clock);
		if (expQ.size() != 0) begin
			check("drain", 19'h0, 19'h1);
			final_report();
		end
	endtask

	// ==========================================================
	// Response watcher: the oldest note is matched to each pulse.
	always @(negedge clock) begin
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0)
				check("unexpected response", 19'h0, 19'h1);
			else begin
				e = expQ.pop_front();
				check("rspWrite", e[1], rspWrite);
				if (!e[1])
					check("rspData", e[0], rspData);
			end
		end
	end

	// ==========================================================
	// Main sequence.
	initial begin
		ce = 1'b1;
		nrst = 1'b0;
		keepSelected = 1'b0;
		reqValid = 1'b0;
		slow = 1'b1;
		req = sram_host_pkg::REQ_RESET;
		fails = 0;
		checksDone = 0;
		void'($urandom(32'h00F9050F));
		repeat (4) @(negedge clock);
		check("pins in reset", sram_host_pkg::PINS_RESET, memPins);
		check("power in reset", 19'h0, activeCurrentState);
		nrst = 1'b1;
		// Boundary and random words written, then read back singly.
		for (int i = 0; i < 8; i++) begin
			addrs[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			access(1'b1, addrs[i], 1'($urandom));
		end
		for (int i = 0; i < 8; i++)
			access(1'b0, addrs[i], 1'b0);
		// Back-to-back burst reads on a quick memory, then a write.
		keepSelected = 1'b1;
		slow = 1'b0;
		for (int i = 7; i >= 0; i--)
			access(1'b0, addrs[i], 1'b0);
		access(1'b1, addrs[3], ~shadow[addrs[3]]);
		access(1'b0, addrs[3], 1'b0);
		// Random mix of reads and writes over the written words.
		for (int i = 0; i < 40; i++) begin
			keepSelected = 1'($urandom);
			slow = 1'($urandom);
			access(1'($urandom), addrs[$urandom % 8], 1'($urandom));
		end
		drain();
		// Power state: idle low in both the mirror and the memory.
		repeat (8) @(negedge clock);
		check("idle power", 19'h0, activeCurrentState);
		check("memory idle", 19'h0, sram_word_model_i.awake);
		// Clock enable low: a waiting read is neither taken nor started.
		ce = 1'b0;
		reqValid = 1'b1;
		req = '{write: 1'b0, addr: addrs[1], data: 1'b0};
		repeat (3) @(negedge clock);
		check("frozen select", 19'h1, memPins.chipSelectN);
		check("frozen ready", 19'h1, reqReady);
		ce = 1'b1;
		// The same read runs once enabled and wakes the memory.
		access(1'b0, addrs[1], 1'b0);
		reqValid = 1'b0;
		repeat (2) @(negedge clock);
		check("woken power", 19'h1, activeCurrentState);
		check("memory woken", 19'h1, sram_word_model_i.awake);
		drain();
		// Reset in mid-write: the write ends when select rises.
		access(1'b1, addrs[0], ~shadow[addrs[0]]);
		reqValid = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b0;
		expQ.delete();
		@(negedge clock);
		check("pins after reset", sram_host_pkg::PINS_RESET, memPins);
		nrst = 1'b1;
		access(1'b0, addrs[0], 1'b0);
		drain();
		final_report();
	end
endmodule
